// ==== btoe_cfg.svh ====
// Constants for the boundary test operation engine
`ifndef BTOE_CFG_SVH
`define BTOE_CFG_SVH
`define BTOE_HALF       20
`define BTOE_CELLS      40
`define BTOE_CTRL_W     12
`define BTOE_AB_OE_BIT  11
`define BTOE_BA_OE_BIT  10
`define BTOE_CTRL_RST   12'hfff
`define BTOE_CELL_RST   40'h00_0000_0000
`define BTOE_OP_BITS    3
`endif

// ==== btoe_pkg.sv ====
// Types and opcode decode for the boundary test operation engine
`default_nettype none
package btoe_pkg;
  typedef enum logic [2:0] {
    op_toggle,
    op_pattern,
    op_signature,
    op_sig_pattern,
    op_sig_count
  } btoe_op_t;

  function automatic btoe_op_t decode_op(input logic [2:0] code);
    btoe_op_t r;
    r = op_toggle;
    case (code[1:0])
      2'b00: r = op_toggle;
      2'b01: r = op_pattern;
      2'b10: r = op_signature;
      default: r = code[2] ? op_sig_count : op_sig_pattern;
    endcase
    return r;
  endfunction
endpackage
`default_nettype wire

// ==== btoe_step_if.sv ====
// Interface between the engine and its next-state calculator
`default_nettype none
interface btoe_step_if;
  btoe_pkg::btoe_op_t op;
  logic [19:0]        out_cells;
  logic [19:0]        in_cells;
  logic [19:0]        in_pins;
  logic [19:0]        nxt_out;
  logic [19:0]        nxt_in;
  modport engine (output op, out_cells, in_cells, in_pins, input nxt_out, nxt_in);
  modport calc   (input op, out_cells, in_cells, in_pins, output nxt_out, nxt_in);
endinterface
`default_nettype wire

// ==== btoe_step.sv ====
// Next shift-stage values for each test operation
`default_nettype none
module btoe_step (
  btoe_step_if.calc st
);
  function automatic logic [39:0] lfsr40(input logic [39:0] s, input logic [39:0] d);
    return {s[38:0], s[39] ^ s[37] ^ s[20] ^ s[18]} ^ d;
  endfunction

  function automatic logic [19:0] lfsr20(input logic [19:0] s, input logic [19:0] d);
    return {s[18:0], s[19] ^ s[16]} ^ d;
  endfunction

  logic [39:0] wide;

  always_comb begin
    wide       = 40'h00_0000_0000;
    st.nxt_out = st.out_cells;
    st.nxt_in  = st.in_cells;
    case (st.op)
      btoe_pkg::op_toggle: begin
        st.nxt_out = ~st.out_cells;
        st.nxt_in  = st.in_pins;
      end
      btoe_pkg::op_pattern: begin
        wide       = lfsr40({st.out_cells, st.in_cells}, 40'h00_0000_0000);
        st.nxt_out = wide[39:20];
        st.nxt_in  = wide[19:0];
      end
      btoe_pkg::op_signature: begin
        wide       = lfsr40({st.out_cells, st.in_cells}, {20'h0_0000, st.in_pins});
        st.nxt_out = wide[39:20];
        st.nxt_in  = wide[19:0];
      end
      btoe_pkg::op_sig_pattern: begin
        st.nxt_out = lfsr20(st.out_cells, 20'h0_0000);
        st.nxt_in  = lfsr20(st.in_cells, st.in_pins);
      end
      btoe_pkg::op_sig_count: begin
        st.nxt_out = 20'(st.out_cells + 20'h0_0001);
        st.nxt_in  = lfsr20(st.in_cells, st.in_pins);
      end
      default: begin
        st.nxt_out = st.out_cells;
        st.nxt_in  = st.in_cells;
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== btoe_engine.sv ====
// Boundary test operation engine: runs self-test operations on the boundary cells
// Overview of operation
// - Operation is decoded from the three low bits of the test control register.
// - Operations run only with run-test instruction active in Run-Test/Idle.
// - X00 sample-toggle, X01 40-bit pattern, X10 40-bit signature; bit 2 ignored.
// - 011 is 20-bit signature plus pattern; 111 is signature plus up-count.
// - Control cells 47 to 36 take no part in any algorithm.
// - Output-enable cells 47 and 46 decide drive or float for each pin group.
// - Run only when the two direction enables differ; otherwise behave as bypass.
// - Sample-toggle loads each input-mode pin into its cell on rising test clock.
// - Sample-toggle inverts output cells on rising edge, drives pins on falling edge.
// - Pattern mode steps a 40-bit LFSR on rising edge, drives pins on falling.
// - An all-zero seed keeps every pattern generator stuck at zero.
// - Signature mode folds input pins into a 40-bit signature per rising edge.
// - 40-bit signature mode leaves output shadow latches and pins unchanged.
// - Signature-pattern mode: 20-bit signature on inputs, 20-bit LFSR on outputs.
// - Signature-count mode: 20-bit signature on inputs, 20-bit counter on outputs.
// - An output-enable cell holding 0 puts its pins in output mode.
// - Boundary read leaves cells untouched so a signature can be shifted out.
`include "btoe_cfg.svh"
`default_nettype none
module btoe_engine (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        tck,
  input  wire logic        run_test_instruction,
  input  wire logic        tap_run_idle,
  input  wire logic [2:0]  test_control_register,
  input  wire logic        scan_load,
  input  wire logic [51:0] scan_data,
  input  wire logic [19:0] a_pin_in,
  input  wire logic [19:0] b_pin_in,
  output logic      [19:0] a_pin_out,
  output logic      [19:0] a_pin_oe,
  output logic      [19:0] b_pin_out,
  output logic      [19:0] b_pin_oe,
  output logic      [39:0] boundary_cells,
  output logic             test_running
);
  logic [2:0]  tck_q, tck_d;
  logic [1:0]  instr_q, instr_d, idle_q, idle_d;
  logic [2:0]  code1_q, code1_d, code2_q, code2_d;
  logic [19:0] a1_q, a1_d, a2_q, a2_d, b1_q, b1_d, b2_q, b2_d;
  logic [11:0] ctrl_q, ctrl_d;
  logic [39:0] cells_q, cells_d, shadow_q, shadow_d;
  logic        run_q, run_d;
  btoe_pkg::btoe_op_t op_q, op_d;
  logic [19:0] a_out_q, a_out_d, b_out_q, b_out_d;
  logic        a_oe_q, a_oe_d, b_oe_q, b_oe_d;
  logic        rise, fall, dir_ab;

  btoe_step_if st ();

  btoe_step u_step (
    .st (st)
  );

  assign rise   = tck_q[1] & ~tck_q[2];
  assign fall   = ~tck_q[1] & tck_q[2];
  // Cell 47 low: A drives B, so B cells are output-mode
  assign dir_ab = ~ctrl_q[`BTOE_AB_OE_BIT];

  // Direction cell 47 picks which cell half feeds the output taps and which the input taps
  always_comb begin
    st.op        = op_q;
    st.out_cells = dir_ab ? cells_q[39:20] : cells_q[19:0];
    st.in_cells  = dir_ab ? cells_q[19:0] : cells_q[39:20];
    st.in_pins   = dir_ab ? a2_q : b2_q;
  end

  always_comb begin
    tck_d   = {tck_q[1:0], tck};
    instr_d = {instr_q[0], run_test_instruction};
    idle_d  = {idle_q[0], tap_run_idle};
    code1_d = test_control_register;
    code2_d = code1_q;
    a1_d    = a_pin_in;
    a2_d    = a1_q;
    b1_d    = b_pin_in;
    b2_d    = b1_q;
    op_d    = btoe_pkg::decode_op(code2_q);
    run_d   = instr_q[1] & idle_q[1]
              & (ctrl_q[`BTOE_AB_OE_BIT] != ctrl_q[`BTOE_BA_OE_BIT]);
    ctrl_d  = ctrl_q;
    cells_d = cells_q;
    shadow_d = shadow_q;
    if (scan_load) begin
      ctrl_d  = scan_data[51:40];
      cells_d = scan_data[39:0];
    end else if (run_q && rise) begin
      // Control cells are never touched here
      if (dir_ab) cells_d = {st.nxt_out, st.nxt_in};
      else        cells_d = {st.nxt_in, st.nxt_out};
    end
    if (run_q && fall && op_q != btoe_pkg::op_signature) begin
      if (dir_ab) shadow_d[39:20] = cells_q[39:20];
      else        shadow_d[19:0]  = cells_q[19:0];
    end
    a_out_d = shadow_q[19:0];
    b_out_d = shadow_q[39:20];
    a_oe_d  = ~ctrl_q[`BTOE_BA_OE_BIT];
    b_oe_d  = ~ctrl_q[`BTOE_AB_OE_BIT];
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      tck_q    <= 3'h0;
      instr_q  <= 2'h0;
      idle_q   <= 2'h0;
      code1_q  <= 3'h0;
      code2_q  <= 3'h0;
      a1_q     <= 20'h0_0000;
      a2_q     <= 20'h0_0000;
      b1_q     <= 20'h0_0000;
      b2_q     <= 20'h0_0000;
      op_q     <= btoe_pkg::op_toggle;
      run_q    <= 1'b0;
      ctrl_q   <= `BTOE_CTRL_RST;
      cells_q  <= `BTOE_CELL_RST;
      shadow_q <= `BTOE_CELL_RST;
      a_out_q  <= 20'h0_0000;
      b_out_q  <= 20'h0_0000;
      a_oe_q   <= 1'b0;
      b_oe_q   <= 1'b0;
    end else begin
      tck_q    <= tck_d;
      instr_q  <= instr_d;
      idle_q   <= idle_d;
      code1_q  <= code1_d;
      code2_q  <= code2_d;
      a1_q     <= a1_d;
      a2_q     <= a2_d;
      b1_q     <= b1_d;
      b2_q     <= b2_d;
      op_q     <= op_d;
      run_q    <= run_d;
      ctrl_q   <= ctrl_d;
      cells_q  <= cells_d;
      shadow_q <= shadow_d;
      a_out_q  <= a_out_d;
      b_out_q  <= b_out_d;
      a_oe_q   <= a_oe_d;
      b_oe_q   <= b_oe_d;
    end
  end

  assign a_pin_out      = a_out_q;
  assign b_pin_out      = b_out_q;
  assign a_pin_oe       = {20{a_oe_q}};
  assign b_pin_oe       = {20{b_oe_q}};
  assign boundary_cells = cells_q;
  assign test_running   = run_q;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_decode_low_bits: assert property (
    (code2_q[1:0] == 2'b10) |=> op_q == btoe_pkg::op_signature)
    else $error("Opcode X10 not decoded as signature");
  a_decode_count: assert property (
    (code2_q == 3'b111) |=> op_q == btoe_pkg::op_sig_count)
    else $error("Opcode 111 not decoded as signature count");
  a_run_needs_idle: assert property (
    run_q |-> $past(instr_q[1]) && $past(idle_q[1]))
    else $error("Operation running outside Run-Test/Idle");
  a_same_dir_bypass: assert property (
    (ctrl_q[`BTOE_AB_OE_BIT] == ctrl_q[`BTOE_BA_OE_BIT]) |=> !run_q)
    else $error("Operation running with both directions equal");
  a_toggle_inverts: assert property (
    (run_q && rise && !scan_load && op_q == btoe_pkg::op_toggle && dir_ab)
    |=> cells_q[39:20] == ~$past(cells_q[39:20]) && cells_q[19:0] == $past(a2_q))
    else $error("Toggle did not invert outputs or sample inputs");
  a_zero_seed_stuck: assert property (
    (run_q && !scan_load && op_q == btoe_pkg::op_pattern && cells_q == 40'h00_0000_0000)
    |=> cells_q == 40'h00_0000_0000)
    else $error("Zero seed produced a pattern");
  a_count_increments: assert property (
    (run_q && rise && !scan_load && op_q == btoe_pkg::op_sig_count && dir_ab)
    |=> cells_q[39:20] == 20'($past(cells_q[39:20]) + 20'h0_0001))
    else $error("Counter did not increment");
  a_sig_shadow_hold: assert property (
    (op_q == btoe_pkg::op_signature && $stable(op_q)) |=> $stable(shadow_q))
    else $error("Shadow latch changed in signature mode");
  a_oe_follows_cell: assert property (
    $stable(ctrl_q) [*2] |-> b_oe_q == ~ctrl_q[`BTOE_AB_OE_BIT]
                             && a_oe_q == ~ctrl_q[`BTOE_BA_OE_BIT])
    else $error("Output enable does not follow enable cell");
  a_idle_no_change: assert property (
    (!run_q && !scan_load) |=> $stable(cells_q))
    else $error("Cells changed while no operation runs");
  a_ctrl_untouched: assert property (
    !scan_load |=> $stable(ctrl_q))
    else $error("Control cells changed without a scan load");
  a_toggle_ba_dir: assert property (
    (run_q && rise && !scan_load && op_q == btoe_pkg::op_toggle && !dir_ab)
    |=> cells_q[19:0] == ~$past(cells_q[19:0]) && cells_q[39:20] == $past(b2_q))
    else $error("Toggle from B side did not invert outputs or sample inputs");
  a_pattern_steps: assert property (
    (run_q && rise && !scan_load && op_q == btoe_pkg::op_pattern && cells_q != 40'h00_0000_0000)
    |=> cells_q != $past(cells_q))
    else $error("Pattern generator did not step");
  a_sig_folds_pins: assert property (
    (run_q && rise && !scan_load && op_q == btoe_pkg::op_signature && dir_ab)
    |=> cells_q[39:1] == ($past(cells_q[38:0]) ^ {20'h0_0000, $past(a2_q[19:1])}))
    else $error("Signature did not fold input pins into input cells");
  a_sigpat_zero_stuck: assert property (
    (run_q && !scan_load && op_q == btoe_pkg::op_sig_pattern && dir_ab
     && cells_q[39:20] == 20'h0_0000)
    |=> cells_q[39:20] == 20'h0_0000)
    else $error("Zero seed produced a 20-bit pattern");
  a_shadow_on_fall: assert property (
    (run_q && fall && op_q != btoe_pkg::op_signature && dir_ab)
    |=> shadow_q[39:20] == $past(cells_q[39:20]))
    else $error("Shadow latches not updated on falling test clock");
  a_pins_follow_shadow: assert property (
    1'b1 |=> a_pin_out == $past(shadow_q[19:0]) && b_pin_out == $past(shadow_q[39:20]))
    else $error("Pins do not follow shadow latches");

  c_toggle_run:  cover property (run_q && rise && op_q == btoe_pkg::op_toggle);
  c_pattern_run: cover property (run_q && rise && op_q == btoe_pkg::op_pattern);
  c_count_run:   cover property (run_q && rise && op_q == btoe_pkg::op_sig_count);
  c_sigpat_run:  cover property (run_q && fall && op_q == btoe_pkg::op_sig_pattern);
  c_sig_run:     cover property (run_q && rise && op_q == btoe_pkg::op_signature);
endmodule
`default_nettype wire

// ==== btoe_ctl_model.sv ====
// Test controller model that produces the test clock in bursts
`default_nettype none
module btoe_ctl_model (
  input  wire logic clock,
  output var  logic tck
);
  timeunit 1ns;
  timeprecision 1ns;
  initial tck = 1'b0;
  // Clock stands low between bursts; one period is 8 system clocks
  task automatic burst(input int n);
    repeat (n) begin
      @(negedge clock) tck = 1'b1;
      repeat (3) @(negedge clock);
      @(negedge clock) tck = 1'b0;
      repeat (3) @(negedge clock);
    end
  endtask
endmodule
`default_nettype wire

// ==== btoe_engine_tb.sv ====
// Self-checking bench for the boundary test operation engine
`default_nettype none
module btoe_engine_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, nrst, tck, instr, idle, scan_load, running;
  logic [2:0]  opc;
  logic [51:0] sdata;
  logic [19:0] a_in, b_in, a_out, a_oe, b_out, b_oe, held;
  logic [39:0] cells;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  btoe_ctl_model btoe_ctl_model_inst (.clock(clock), .tck(tck));
  btoe_engine btoe_engine_inst (.clock(clock), .nrst(nrst), .tck(tck),
    .run_test_instruction(instr), .tap_run_idle(idle), .test_control_register(opc),
    .scan_load(scan_load), .scan_data(sdata), .a_pin_in(a_in), .b_pin_in(b_in),
    .a_pin_out(a_out), .a_pin_oe(a_oe), .b_pin_out(b_out), .b_pin_oe(b_oe),
    .boundary_cells(cells), .test_running(running));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One step of the 40-bit generator, x^40 + x^38 + x^21 + x^19, pins folded into the low half
  function automatic logic [39:0] ref_lfsr(input logic [39:0] s, input logic [19:0] pins);
    logic fb;
    fb = s[39] ^ s[37] ^ s[20] ^ s[18];
    return {s[38:0], fb} ^ {20'h0_0000, pins};
  endfunction
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Seed and control cells go in before any run
  task automatic load(input logic [51:0] d);
    @(negedge clock);
    scan_load = 1'b1;
    sdata = d;
    @(negedge clock);
    scan_load = 1'b0;
    wait_clk(3);
  endtask
  task automatic run(input logic [2:0] op, input logic go_idle, input int n, input logic exp);
    opc = op;
    wait_clk(4);
    instr = 1'b1;
    idle = go_idle;
    wait_clk(6);
    chk("test_running", {39'h0, exp}, {39'h0, running});
    btoe_ctl_model_inst.burst(n);
    wait_clk(4);
    instr = 1'b0;
    idle = 1'b0;
    wait_clk(6);
  endtask
  task automatic t_gating();
    load({12'h3ff, 40'h12_3456_789a});
    run(3'h0, 1'b1, 2, 1'b0);
    chk("cells equal enables", 40'h12_3456_789a, cells);
    load({12'h7ff, 40'h12_3456_789a});
    run(3'h0, 1'b0, 2, 1'b0);
    chk("cells idle low", 40'h12_3456_789a, cells);
  endtask
  task automatic t_toggle(input logic dir);
    a_in = 20'h0_f0f0;
    load({dir ? 12'hbff : 12'h7ff, 20'h5_5555, 20'h3_3333});
    run(3'h4, 1'b1, 1, 1'b1);
    chk("cells toggle", dir ? {b_in, 20'hc_cccc} : {20'ha_aaaa, a_in}, cells);
    chk("out pins", {20'h0, dir ? 20'hc_cccc : 20'ha_aaaa}, {20'h0, dir ? a_out : b_out});
    chk("oe pins", {dir ? 20'hf_ffff : 20'h0, dir ? 20'h0 : 20'hf_ffff}, {a_oe, b_oe});
  endtask
  task automatic t_count();
    a_in = 20'h0_0000;
    load({12'h7ff, 20'hf_ffff, 20'h0_0000});
    run(3'h7, 1'b1, 2, 1'b1);
    chk("cells count", {20'h0_0001, 20'h0_0000}, cells);
    chk("count pins", {20'h0, 20'h0_0001}, {20'h0, b_out});
  endtask
  task automatic t_stuck(input logic [2:0] op);
    a_in = 20'h0_0000;
    load({12'h7ff, 40'h00_0000_0000});
    run(op, 1'b1, 3, 1'b1);
    chk("cells zero seed", 40'h00_0000_0000, cells);
  endtask
  task automatic t_pattern();
    logic [39:0] want;
    want = ref_lfsr(ref_lfsr(40'h80_0000_0001, 20'h0_0000), 20'h0_0000);
    load({12'h7ff, 40'h80_0000_0001});
    run(3'h1, 1'b1, 2, 1'b1);
    chk("cells pattern", want, cells);
    chk("pattern pins", {20'h0_0000, want[39:20]}, {20'h0_0000, b_out});
  endtask
  task automatic t_signature();
    logic [39:0] want;
    want = ref_lfsr(ref_lfsr(ref_lfsr({20'h1_2345, 20'h0_0001}, 20'h0_f0f0), 20'h0_f0f0),
                    20'h0_f0f0);
    a_in = 20'h0_f0f0;
    held = b_out;
    load({12'h7ff, 20'h1_2345, 20'h0_0001});
    run(3'h2, 1'b1, 3, 1'b1);
    chk("held pins", {20'h0, held}, {20'h0, b_out});
    chk("cells signature", want, cells);
  endtask
  // Reset in the middle of a run returns every output to its idle value
  task automatic t_reset();
    load({12'h7ff, 40'h12_3456_789a});
    opc = 3'h0;
    wait_clk(4);
    instr = 1'b1;
    idle = 1'b1;
    btoe_ctl_model_inst.burst(1);
    nrst = 1'b0;
    wait_clk(2);
    chk("reset cells", 40'h00_0000_0000, cells);
    chk("reset pins", 40'h00_0000_0000, {a_out, b_out});
    chk("reset oe", 40'h00_0000_0000, {a_oe, b_oe});
    chk("reset running", 40'h00_0000_0000, {39'h0, running});
    nrst = 1'b1;
    wait_clk(6);
    chk("running after reset", 40'h00_0000_0000, {39'h0, running});
    instr = 1'b0;
    idle = 1'b0;
    wait_clk(6);
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    nrst = 1'b0;
    instr = 1'b0;
    idle = 1'b0;
    opc = 3'h0;
    scan_load = 1'b0;
    sdata = 52'h0_0000_0000_0000;
    a_in = 20'h0_0000;
    b_in = 20'h9_0909;
    wait_clk(6);
    nrst = 1'b1;
    t_gating();
    t_toggle(1'b0);
    t_toggle(1'b1);
    t_count();
    t_pattern();
    t_stuck(3'h5);
    t_stuck(3'h3);
    t_signature();
    t_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
